// ---- inc/dma_pkg.sv ----
package dma_pkg;

  // ==========================================================
  // sizes
  localparam int NCH = 32;
  localparam int NATTR = 5;
  localparam int AW = 12;

  // ==========================================================
  // register offsets
  localparam logic [11:0] OFF_STATUS = 12'h000;
  localparam logic [11:0] OFF_CONFIG = 12'h004;
  localparam logic [11:0] OFF_BASE = 12'h008;
  localparam logic [11:0] OFF_ALT_BASE = 12'h00C;
  localparam logic [11:0] OFF_SW_REQ = 12'h014;
  localparam logic [11:0] OFF_BURST_SET = 12'h018;
  localparam logic [11:0] OFF_BURST_CLR = 12'h01C;
  localparam logic [11:0] OFF_MASK_SET = 12'h020;
  localparam logic [11:0] OFF_MASK_CLR = 12'h024;
  localparam logic [11:0] OFF_ENABLE_SET = 12'h028;
  localparam logic [11:0] OFF_ENABLE_CLR = 12'h02C;
  localparam logic [11:0] OFF_ALT_SET = 12'h030;
  localparam logic [11:0] OFF_ALT_CLR = 12'h034;
  localparam logic [11:0] OFF_PRIO_SET = 12'h038;
  localparam logic [11:0] OFF_PRIO_CLR = 12'h03C;
  localparam logic [11:0] OFF_ERR_CLR = 12'h04C;
  // set/clear pair index = addr[5:3] minus this
  localparam logic [2:0] PAIR_BIAS = 3'h3;

  // ==========================================================
  // attribute indices within the set/clear pairs
  localparam logic [2:0] ATTR_BURST = 3'h0;
  localparam logic [2:0] ATTR_MASK = 3'h1;
  localparam logic [2:0] ATTR_ENABLE = 3'h2;
  localparam logic [2:0] ATTR_ALT = 3'h3;
  localparam logic [2:0] ATTR_PRIO = 3'h4;
  localparam logic [31:0] ATTR_RESET = 32'h0000_0000;

  // ==========================================================
  // fields and fixed values
  localparam int EN_BIT = 0;
  localparam int ERR_BIT = 0;
  localparam logic [31:0] STATUS_FIXED = 32'h101F_0000;
  localparam logic [31:0] BASE_MASK = 32'hFFFF_FC00;
  localparam logic [31:0] ALT_OFFSET = 32'h0000_0200;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [3:0] DESC_ZERO = 4'h0;
  localparam logic [1:0] DESC_LAST = 2'h2;
  localparam int CTL_SIZE_LSB = 0;
  localparam int CTL_SRC_INC = 2;
  localparam int CTL_DST_INC = 3;
  localparam int CTL_CNT_LSB = 4;
  localparam int CTL_CNT_W = 10;

  // ==========================================================
  // system bus codes
  localparam logic [1:0] TRANS_IDLE = 2'h0;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  // ==========================================================
  // transfer engine states
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_FA = 7'h02,
    S_FD = 7'h04,
    S_RA = 7'h08,
    S_RD = 7'h10,
    S_WA = 7'h20,
    S_WD = 7'h40
  } state_e;

endpackage

// ---- hw/dma_arbiter.sv ----
`timescale 1ns/1ps
module dma_arbiter (
  input wire logic [31:0] pend,
  input wire logic [31:0] high,
  output logic valid,
  output logic [4:0] idx
);

  // ==========================================================
  // lowest set bit wins
  function automatic logic [5:0] first_set(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = dma_pkg::NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  logic [31:0] hi_pend;
  logic [5:0] pick;

  // high group first, then the normal group
  always_comb begin
    hi_pend = pend & high;
    pick = (|hi_pend) ? first_set(hi_pend) : first_set(pend);
    valid = pick[5];
    idx = pick[4:0];
  end

endmodule

// ---- hw/dma_control_core.sv ----
`timescale 1ns/1ps
// Function
// - a peripheral request line starts its channel's transfer
// - writing the software request register starts a channel
// - fixed order ch0 first; high group beats normal group
// - priority set/clear registers move channels between groups
// - source and destination each increment or stay fixed
// - one completion interrupt per channel plus an error interrupt
// - peripheral-bus slave serves all register reads and writes
// - system-bus master runs the data read and write cycles
// - status bits 7 to 4 read an unspecified value
// - primary and alternate control base pointers at adjacent words
// - burst-use set and clear registers, one bit per channel
// - request-mask set and clear block peripheral requests
// - channel-enable set and clear enable channels
// - primary/alternate set and clear choose the structure
// - bus-error clear register acknowledges a recorded error
module dma_control_core (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [31:0] HADDR,
  output logic [1:0] HTRANS,
  output logic HWRITE,
  output logic [2:0] HSIZE,
  output logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  input wire logic HREADY,
  input wire logic HRESP,
  input wire logic [31:0] DMA_REQ,
  output logic [31:0] DONE_IRQ,
  output logic ERR_IRQ
);
  // ==========================================================
  // decode helpers
  function automatic logic is_pair(input logic [11:0] a);
    return (a >= dma_pkg::OFF_BURST_SET) && (a <= dma_pkg::OFF_PRIO_CLR);
  endfunction
  function automatic logic [2:0] pair_index(input logic [11:0] a);
    return a[5:3] - dma_pkg::PAIR_BIAS;
  endfunction
  function automatic logic mapped(input logic [11:0] a);
    return (a[1:0] == 2'h0) && (is_pair(a) ||
      a == dma_pkg::OFF_STATUS || a == dma_pkg::OFF_CONFIG ||
      a == dma_pkg::OFF_BASE || a == dma_pkg::OFF_ALT_BASE ||
      a == dma_pkg::OFF_SW_REQ || a == dma_pkg::OFF_ERR_CLR);
  endfunction

  // ==========================================================
  // state
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic master_en_r;
  logic [31:0] base_r;
  logic [31:0] sw_pend_r;
  logic err_r;
  logic [31:0] attr_r [dma_pkg::NATTR];
  logic [31:0] done_r;
  dma_pkg::state_e state_r;
  logic [4:0] ch_r;
  logic [1:0] fidx_r;
  logic [31:0] src_r;
  logic [31:0] dst_r;
  logic [1:0] size_r;
  logic src_inc_r;
  logic dst_inc_r;
  logic [9:0] cnt_r;
  logic [31:0] data_r;
  logic [31:0] haddr_r;
  logic [1:0] htrans_r;
  logic hwrite_r;
  logic [2:0] hsize_r;
  logic [31:0] hwdata_r;
  logic setup;
  logic wr_en;
  logic [31:0] rd_mux;
  logic [31:0] alt_base;
  logic [31:0] pending;
  logic gnt_valid;
  logic [4:0] gnt_idx;
  logic [31:0] sw_take;
  logic [31:0] en_hw_clr;
  logic bus_err;
  logic fin;
  logic [31:0] desc_base;
  logic [31:0] step;
  logic [31:0] ch_bit;

  // ==========================================================
  // peripheral-bus slave
  // zero-wait access phase; the read word is built in the setup phase
  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PWRITE & pready_r & ~pslverr_r; // refused never writes
  assign alt_base = base_r + dma_pkg::ALT_OFFSET;
  // read multiplexer; write-only registers read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_pair(PADDR)) begin
      rd_mux = attr_r[pair_index(PADDR)];
    end else begin
      unique case (PADDR)
        dma_pkg::OFF_STATUS: rd_mux = dma_pkg::STATUS_FIXED |
          {31'h0000_0000, master_en_r};
        dma_pkg::OFF_BASE: rd_mux = base_r;
        dma_pkg::OFF_ALT_BASE: rd_mux = alt_base;
        dma_pkg::OFF_ERR_CLR: rd_mux = {31'h0000_0000, err_r};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end
  // answer registers: unmapped offsets report a slave error
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped(PADDR);
      prdata_r <= (setup & ~PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================================
  // controller configuration and base pointer
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      master_en_r <= 1'b0;
      base_r <= 32'h0000_0000;
    end else begin
      if (wr_en && PADDR == dma_pkg::OFF_CONFIG) begin
        master_en_r <= PWDATA[dma_pkg::EN_BIT];
      end
      if (wr_en && PADDR == dma_pkg::OFF_BASE) begin
        base_r <= PWDATA & dma_pkg::BASE_MASK;
      end
    end
  end
  // ==========================================================
  // software requests stay pending until the channel is granted
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sw_pend_r <= 32'h0000_0000;
    end else begin
      sw_pend_r <= (sw_pend_r & ~sw_take) |
        ((wr_en && PADDR == dma_pkg::OFF_SW_REQ) ? PWDATA : 32'h0000_0000);
    end
  end
  // ==========================================================
  // per-channel attributes, one set/clear pair each
  generate
    for (genvar g = 0; g < dma_pkg::NATTR; g++) begin : g_attr
      logic hit;
      logic [31:0] set_v;
      logic [31:0] clr_v;
      logic [31:0] hw_v;
      assign hit = wr_en && is_pair(PADDR) && pair_index(PADDR) == 3'(g);
      assign set_v = (hit && !PADDR[2]) ? PWDATA : 32'h0000_0000;
      assign clr_v = (hit && PADDR[2]) ? PWDATA : 32'h0000_0000;
      assign hw_v = (3'(g) == dma_pkg::ATTR_ENABLE) ? en_hw_clr : 32'h0000_0000;
      // software set wins over a completion clearing the enable
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          attr_r[g] <= dma_pkg::ATTR_RESET;
        end else begin
          attr_r[g] <= ((attr_r[g] & ~hw_v) | set_v) & ~clr_v;
        end
      end
    end
  endgenerate

  // ==========================================================
  // request gathering and arbitration
  always_comb begin
    pending = (DMA_REQ & ~attr_r[dma_pkg::ATTR_MASK]) | sw_pend_r;
    pending = pending & attr_r[dma_pkg::ATTR_ENABLE];
    pending = master_en_r ? pending : 32'h0000_0000;
  end
  dma_arbiter dma_arbiter_inst (
    .pend(pending),
    .high(attr_r[dma_pkg::ATTR_PRIO]),
    .valid(gnt_valid),
    .idx(gnt_idx)
  );
  // ==========================================================
  // engine side conditions
  always_comb begin
    ch_bit = 32'h0000_0001 << ch_r;
    sw_take = (state_r == dma_pkg::S_IDLE && gnt_valid) ?
      (32'h0000_0001 << gnt_idx) : 32'h0000_0000;
    desc_base = attr_r[dma_pkg::ATTR_ALT][gnt_idx] ? alt_base : base_r;
    // error answer on a data phase
    bus_err = HREADY && HRESP && (state_r == dma_pkg::S_FD ||
      state_r == dma_pkg::S_RD || state_r == dma_pkg::S_WD);
    fin = bus_err || (HREADY && state_r == dma_pkg::S_WD && cnt_r == 10'h000);
    en_hw_clr = fin ? ch_bit : 32'h0000_0000;
    step = 32'h0000_0001 << size_r;
  end

  // ==========================================================
  // descriptor fetch, then read/write per item; no pipelining: simpler, half the bandwidth
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= dma_pkg::S_IDLE;
      ch_r <= 5'h00;
      fidx_r <= 2'h0;
      src_r <= 32'h0000_0000;
      dst_r <= 32'h0000_0000;
      size_r <= 2'h0;
      src_inc_r <= 1'b0;
      dst_inc_r <= 1'b0;
      cnt_r <= 10'h000;
      data_r <= 32'h0000_0000;
      haddr_r <= 32'h0000_0000;
      htrans_r <= dma_pkg::TRANS_IDLE;
      hwrite_r <= 1'b0;
      hsize_r <= dma_pkg::SIZE_WORD;
      hwdata_r <= 32'h0000_0000;
    end else begin
      unique case (state_r)
        dma_pkg::S_IDLE: begin
          if (gnt_valid) begin
            ch_r <= gnt_idx;
            fidx_r <= 2'h0;
            haddr_r <= desc_base + {23'h000000, gnt_idx, dma_pkg::DESC_ZERO};
            htrans_r <= dma_pkg::TRANS_NONSEQ;
            hwrite_r <= 1'b0;
            hsize_r <= dma_pkg::SIZE_WORD;
            state_r <= dma_pkg::S_FA;
          end
        end
        dma_pkg::S_FA, dma_pkg::S_RA, dma_pkg::S_WA: begin
          if (HREADY) begin
            htrans_r <= dma_pkg::TRANS_IDLE;
            if (state_r == dma_pkg::S_FA) begin
              state_r <= dma_pkg::S_FD;
            end else if (state_r == dma_pkg::S_RA) begin
              state_r <= dma_pkg::S_RD;
            end else begin
              // little-endian lane placement
              hwdata_r <= data_r << {dst_r[1:0], 3'h0};
              state_r <= dma_pkg::S_WD;
            end
          end
        end
        dma_pkg::S_FD: begin
          if (bus_err) begin
            state_r <= dma_pkg::S_IDLE;
          end else if (HREADY) begin
            if (fidx_r == dma_pkg::DESC_LAST) begin
              size_r <= HRDATA[dma_pkg::CTL_SIZE_LSB +: 2];
              src_inc_r <= HRDATA[dma_pkg::CTL_SRC_INC];
              dst_inc_r <= HRDATA[dma_pkg::CTL_DST_INC];
              cnt_r <= HRDATA[dma_pkg::CTL_CNT_LSB +: dma_pkg::CTL_CNT_W];
              haddr_r <= src_r;
              hsize_r <= {1'b0, HRDATA[dma_pkg::CTL_SIZE_LSB +: 2]};
              htrans_r <= dma_pkg::TRANS_NONSEQ;
              state_r <= dma_pkg::S_RA;
            end else begin
              if (fidx_r == 2'h0) begin
                src_r <= HRDATA;
              end else begin
                dst_r <= HRDATA;
              end
              fidx_r <= fidx_r + 2'h1;
              haddr_r <= haddr_r + dma_pkg::WORD_STEP;
              htrans_r <= dma_pkg::TRANS_NONSEQ;
              state_r <= dma_pkg::S_FA;
            end
          end
        end
        dma_pkg::S_RD: begin
          if (bus_err) begin
            state_r <= dma_pkg::S_IDLE;
          end else if (HREADY) begin
            data_r <= HRDATA >> {src_r[1:0], 3'h0};
            haddr_r <= dst_r;
            hwrite_r <= 1'b1;
            htrans_r <= dma_pkg::TRANS_NONSEQ;
            state_r <= dma_pkg::S_WA;
          end
        end
        dma_pkg::S_WD: begin
          hwrite_r <= ~HREADY; // stands through wait states
          if (bus_err || (HREADY && cnt_r == 10'h000)) begin
            state_r <= dma_pkg::S_IDLE;
          end else if (HREADY) begin
            src_r <= src_inc_r ? src_r + step : src_r;
            dst_r <= dst_inc_r ? dst_r + step : dst_r;
            haddr_r <= src_inc_r ? src_r + step : src_r;
            cnt_r <= cnt_r - 10'h001;
            htrans_r <= dma_pkg::TRANS_NONSEQ;
            state_r <= dma_pkg::S_RA;
          end
        end
        default: begin
          htrans_r <= dma_pkg::TRANS_IDLE;
          state_r <= dma_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // completion pulses and the sticky bus error
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      done_r <= 32'h0000_0000;
    end else begin
      done_r <= (fin && !bus_err) ? ch_bit : 32'h0000_0000;
    end
  end
  // a new error in the clearing cycle keeps the flag set
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      err_r <= 1'b0;
    end else begin
      err_r <= bus_err | (err_r & ~(wr_en && PADDR == dma_pkg::OFF_ERR_CLR &&
        PWDATA[dma_pkg::ERR_BIT]));
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign HADDR = haddr_r;
  assign HTRANS = htrans_r;
  assign HWRITE = hwrite_r;
  assign HSIZE = hsize_r;
  assign HWDATA = hwdata_r;
  assign DONE_IRQ = done_r;
  assign ERR_IRQ = err_r;
endmodule

// ---- verif/dma_mem_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// system bus memory with wait states and one faulting word
module dma_mem_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic [3:0] wait_n,
  input wire logic [31:0] err_addr,
  output logic [31:0] hrdata,
  output logic hready,
  output logic hresp
);
  logic [31:0] mem [0:1023];
  logic busy_r;
  logic wr_r;
  logic [2:0] sz_r;
  logic [3:0] cnt_r;
  logic [31:0] a_r;
  logic [31:0] last_r;
  logic [31:0] lane;
  logic fin;
  // ready while idle and at the end of a data phase; error only at the end of a data phase
  assign fin = busy_r && cnt_r == 4'h0;
  assign hready = !busy_r || fin;
  assign hresp = fin && a_r == err_addr;
  // a released read bus never shows the word it last carried
  assign hrdata = (fin && !wr_r) ? mem[a_r[11:2]] : ~last_r;
  assign lane = sz_r == 3'h0 ? 32'hFF << {a_r[1:0], 3'h0} :
                sz_r == 3'h1 ? 32'hFFFF << {a_r[1], 4'h0} : 32'hFFFF_FFFF;
  // plain always: the bench preloads the same array
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      last_r <= 32'h0;
    end else if (busy_r) begin
      if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else begin
        busy_r <= 1'b0;
        last_r <= hrdata;
        if (wr_r && !hresp) begin
          mem[a_r[11:2]] <= (mem[a_r[11:2]] & ~lane) | (hwdata & lane);
        end
      end
    end else if (htrans == 2'h2) begin
      busy_r <= 1'b1;
      a_r <= haddr;
      wr_r <= hwrite;
      sz_r <= hsize;
      cnt_r <= wait_n;
    end
  end
endmodule

// ---- verif/dma_control_core_checker.sv ----
`timescale 1ns/1ps
// ==========================================================
// port checks of the control core
module dma_control_core_checker (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HRESP,
  input wire logic [31:0] DONE_IRQ,
  input wire logic ERR_IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic rd;
  logic clr;
  logic wdone;
  // access-cycle events
  assign rd = PREADY && !PWRITE;
  assign clr = PREADY && PWRITE && PADDR == dma_pkg::OFF_ERR_CLR && PWDATA[0];
  assign wdone = HWRITE && HREADY && HTRANS == dma_pkg::TRANS_IDLE;
  a_ready_zero_wait:
    assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
  a_ready_has_setup:
    assert property (PREADY |-> $past(PSEL) && !$past(PENABLE)) else $error("stray ready");
  a_unmapped_error:
    assert property (PREADY && PADDR == 12'h010 |-> PSLVERR) else $error("no slave error");
  a_status_constant:
    assert property (rd && PADDR == dma_pkg::OFF_STATUS |->
      (PRDATA & 32'hFFFF_FF0E) == dma_pkg::STATUS_FIXED) else $error("status bits wrong");
  a_config_reads_zero:
    assert property (rd && PADDR == dma_pkg::OFF_CONFIG |-> PRDATA == 32'h0)
      else $error("config read not zero");
  a_alt_base_offset:
    assert property (rd && PADDR == dma_pkg::OFF_ALT_BASE |-> PRDATA[9:0] == 10'h200)
      else $error("alternate base offset wrong");
  a_single_transfer:
    assert property (HTRANS == dma_pkg::TRANS_NONSEQ && HREADY |=>
      HTRANS == dma_pkg::TRANS_IDLE) else $error("pipelined transfer");
  a_error_flag_set:
    assert property (HRESP && HREADY |-> ##[1:2] ERR_IRQ) else $error("error not flagged");
  a_error_flag_held:
    assert property ($fell(ERR_IRQ) |-> $past(clr) || $past(clr, 2))
      else $error("error dropped without clear");
  a_done_one_pulse:
    assert property (DONE_IRQ != 32'h0 |-> $onehot(DONE_IRQ) ##1 DONE_IRQ == 32'h0)
      else $error("completion not a single pulse");
  a_done_after_write:
    assert property (DONE_IRQ != 32'h0 |-> $past(wdone) || $past(wdone, 2))
      else $error("completion without final write");
  c_done: cover property (DONE_IRQ != 32'h0);
  c_error: cover property ($rose(ERR_IRQ));
  c_refused: cover property (PREADY && PSLVERR);
endmodule

bind dma_control_core dma_control_core_checker dma_control_core_checker_inst (
  .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRESP(HRESP),
  .DONE_IRQ(DONE_IRQ), .ERR_IRQ(ERR_IRQ)
);

// ---- verif/multichannel_dma_control_core_bench.sv ----
`timescale 1ns/1ps
`define CHK(g, e, m) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e); \
  end \
end

// ==========================================================
// register and transfer tests of the control core
module multichannel_dma_control_core_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] dma_req = 32'h0;
  logic [3:0] wait_n = 4'h0;
  logic [31:0] err_addr = 32'hFFFF_FFFC;
  logic [31:0] prdata, haddr, hwdata, hrdata, done_irq, rdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic pready, pslverr, hwrite, hready, hresp, err_irq, rerr;
  logic [31:0] done_seen = 32'h0;
  logic [31:0] done_log [$];
  int pk[3] = '{0, 3, 4};
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;

  dma_control_core dma_control_core_inst (
    .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HRDATA(hrdata), .HREADY(hready), .HRESP(hresp), .DMA_REQ(dma_req),
    .DONE_IRQ(done_irq), .ERR_IRQ(err_irq)
  );
  dma_mem_model dma_mem_model_inst (
    .clk(clk), .nrst(nrst), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .wait_n(wait_n), .err_addr(err_addr),
    .hrdata(hrdata), .hready(hready), .hresp(hresp)
  );

  always #5 clk = ~clk;

  // completion log and hang limit
  always @(posedge clk) begin
    cycles++;
    if (done_irq != 32'h0) begin
      done_seen = done_seen | done_irq;
      done_log.push_back(done_irq);
    end
    if (cycles == 20000) begin
      fails++;
      $display("MISMATCH t=%0t run timed out", $time);
      results();
    end
  end

  // ==========================================================
  // access tasks
  // whole word accesses
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(a, 1'b0, 32'h0);
    `CHK(rdata & m, e, "read")
  endtask

  function automatic logic [31:0] ctl(input int n, input logic si, input logic di);
    return {18'h0, 10'(n - 1), di, si, 2'h2};
  endfunction

  task automatic desc(input int ch, input int alt, input logic [31:0] s, d, c);
    int i;
    i = 256 + alt * 128 + ch * 4;
    dma_mem_model_inst.mem[i] = s;
    dma_mem_model_inst.mem[i + 1] = d;
    dma_mem_model_inst.mem[i + 2] = c;
  endtask

  // hardware requests stay high until completion or 600 cycles, then drop
  task automatic run(input int ch, input int alt, input logic [31:0] s, d, c, input logic hw);
    desc(ch, alt, s, d, c);
    apb(alt ? dma_pkg::OFF_ALT_SET : dma_pkg::OFF_ALT_CLR, 1'b1, 32'h1 << ch);
    apb(dma_pkg::OFF_ENABLE_SET, 1'b1, 32'h1 << ch);
    done_seen = 32'h0;
    if (hw) begin
      dma_req[ch] <= 1'b1;
    end else begin
      apb(dma_pkg::OFF_SW_REQ, 1'b1, 32'h1 << ch);
    end
    for (int i = 0; i < 600 && !done_seen[ch]; i++) begin
      @(posedge clk);
    end
    dma_req <= 32'h0;
  endtask

  task automatic prio(input logic [31:0] high, input logic [31:0] first);
    apb(dma_pkg::OFF_PRIO_SET, 1'b1, high);
    apb(dma_pkg::OFF_ENABLE_SET, 1'b1, 32'h44);
    done_log.delete();
    apb(dma_pkg::OFF_SW_REQ, 1'b1, 32'h44);
    for (int i = 0; i < 300 && done_log.size() < 2; i++) begin
      @(posedge clk);
    end
    `CHK(done_log[0], first, "first done")
    apb(dma_pkg::OFF_PRIO_CLR, 1'b1, 32'hFFFF_FFFF);
  endtask

  task automatic note(input string s);
    $display("test %s finished", s);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial begin
    logic [11:0] a;
    for (int i = 0; i < 1024; i++) begin
      dma_mem_model_inst.mem[i] = (i < 256) ? 32'hC0DE_0000 + i : 32'h0;
    end
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(dma_pkg::OFF_STATUS, dma_pkg::STATUS_FIXED, 32'hFFFF_FF0F);
    for (int k = 0; k < 10; k++) begin
      rd(12'h018 + 12'(4 * k), 32'h0, 32'hFFFF_FFFF);
    end
    apb(12'h010, 1'b0, 32'h0);
    `CHK(rerr, 1'b1, "unmapped")
    rd(dma_pkg::OFF_CONFIG, 32'h0, 32'hFFFF_FFFF);
    note("reset");
    apb(dma_pkg::OFF_CONFIG, 1'b1, 32'h0000_0001);
    rd(dma_pkg::OFF_STATUS, dma_pkg::STATUS_FIXED | 32'h1, 32'hFFFF_FF0F);
    apb(dma_pkg::OFF_MASK_SET, 1'b1, 32'hFFFF_FFFF);
    apb(dma_pkg::OFF_ENABLE_SET, 1'b1, 32'hFFFF_FFFF);
    apb(dma_pkg::OFF_MASK_CLR, 1'b1, 32'h0000_00FF);
    rd(dma_pkg::OFF_MASK_SET, 32'hFFFF_FF00, 32'hFFFF_FFFF);
    rd(dma_pkg::OFF_ENABLE_CLR, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    apb(12'h02E, 1'b1, 32'hFFFF_FFFF);
    `CHK(rerr, 1'b1, "misaligned")
    rd(dma_pkg::OFF_ENABLE_SET, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    foreach (pk[k]) begin
      a = 12'h018 + 12'(8 * pk[k]);
      apb(a, 1'b1, 32'hA5A5_A5A5);
      apb(a + 12'h4, 1'b1, 32'h0000_FFFF);
      apb(a, 1'b1, 32'h0);
      rd(a, 32'hA5A5_0000, 32'hFFFF_FFFF);
      rd(a + 12'h4, 32'hA5A5_0000, 32'hFFFF_FFFF);
      apb(a + 12'h4, 1'b1, 32'hFFFF_FFFF);
    end
    apb(dma_pkg::OFF_BASE, 1'b1, 32'h0000_07FF);
    rd(dma_pkg::OFF_BASE, 32'h0000_0400, 32'hFFFF_FFFF);
    rd(dma_pkg::OFF_ALT_BASE, 32'h0000_0600, 32'hFFFF_FFFF);
    note("registers");
    wait_n <= 4'h2;
    run(3, 0, 32'h0, 32'h800, ctl(4, 1, 1), 1'b0);
    for (int k = 0; k < 4; k++) begin
      `CHK(dma_mem_model_inst.mem[512 + k], 32'hC0DE_0000 + k, "copy")
    end
    wait_n <= 4'h0;
    run(4, 0, 32'h10, 32'h820, ctl(3, 0, 1), 1'b1);
    for (int k = 0; k < 3; k++) begin
      `CHK(dma_mem_model_inst.mem[520 + k], 32'hC0DE_0004, "fixed source")
    end
    run(9, 1, 32'h20, 32'h840, ctl(3, 1, 0), 1'b0);
    `CHK(dma_mem_model_inst.mem[528], 32'hC0DE_000A, "fixed dest")
    `CHK(dma_mem_model_inst.mem[529], 32'h0, "fixed dest")
    run(10, 0, 32'h42, 32'h8A1, ctl(2, 1, 1) & ~32'h2, 1'b0);
    `CHK(dma_mem_model_inst.mem[552], 32'h00C0_DE00, "byte lanes")
    run(12, 0, 32'h0, 32'h860, ctl(1, 1, 1), 1'b1);
    `CHK(done_seen[12], 1'b0, "masked")
    note("transfers");
    desc(2, 0, 32'h0, 32'h880, ctl(1, 1, 1));
    desc(6, 0, 32'h4, 32'h884, ctl(1, 1, 1));
    prio(32'h40, 32'h40);
    prio(32'h0, 32'h4);
    note("priority");
    err_addr <= 32'h0000_0030;
    run(7, 0, 32'h30, 32'h8C0, ctl(2, 1, 1), 1'b0);
    `CHK(err_irq, 1'b1, "error irq")
    rd(dma_pkg::OFF_ERR_CLR, 32'h1, 32'h1);
    apb(dma_pkg::OFF_ERR_CLR, 1'b1, 32'h1);
    rd(dma_pkg::OFF_ERR_CLR, 32'h0, 32'h1);
    `CHK(err_irq, 1'b0, "error cleared")
    err_addr <= 32'hFFFF_FFFC;
    note("error");
    apb(dma_pkg::OFF_CONFIG, 1'b1, 32'h0);
    run(5, 0, 32'h0, 32'h8E0, ctl(1, 1, 1), 1'b0);
    `CHK(done_seen[5], 1'b0, "disabled")
    apb(dma_pkg::OFF_CONFIG, 1'b1, 32'h1);
    for (int i = 0; i < 100 && !done_seen[5]; i++) begin
      @(posedge clk);
    end
    `CHK(done_seen[5], 1'b1, "enabled")
    note("enable");
    results();
  end
endmodule
